// *** rtl/pors_defines.vh ***
/*
 * Shared constants of the power-on reset sequencer: register map,
 * field positions, reset values, sequencer timing and machine-cycle layout.
 * Assumes it is included by bare name from the rtl files.
 */
`ifndef PORS_DEFINES_VH
`define PORS_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define PORS_ADDR_CONV_CTRL0 8'hD8
`define PORS_ADDR_IRQ_STATUS 8'h00
`define PORS_ADDR_IRQ_MASK 8'h04
`define PORS_ADDR_SEQ_STATUS 8'h08
`define PORS_ADDR_PORT_LATCH 8'h0C
`define PORS_ADDR_CONTROL 8'h10

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PORS_SYSTEM_CLOCK_OUTPUT_PIN_EN_BIT 6
`define PORS_CONV_CTRL0_RST 8'h00
`define PORS_PORT_LATCH_RST 1'b1
`define PORS_CTRL_SLOW_BIT 0
`define PORS_CTRL_SWPD_BIT 1
`define PORS_IRQ_FAIL_BIT 0
`define PORS_IRQ_RELEASE_BIT 1
`define PORS_IRQ_EXTREL_BIT 2
`define PORS_IRQ_W 3

// ----------------------------------------------------------------
// sequencer timing, in oscillator ticks, and machine-cycle states
// ----------------------------------------------------------------
`define PORS_SETTLE_RC_CYCLES 10'd768
`define PORS_DET_WINDOW 5'd16
`define PORS_SLOW_DIV 5'd31
`define PORS_STATES_PER_MC 3'd6
`define PORS_THIRD_STATE 3'd2
`define PORS_LAST_STATE 3'd5

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define PORS_RESP_OKAY 2'b00
`define PORS_RESP_SLVERR 2'b10

`endif

// *** rtl/pors_clk_switch.v ***
/*
 * Glitch-free selection of the chip clock between the RC oscillator
 * and the main oscillator, both given as one-cycle tick enables.
 * Assumes both ticks are synchronous to the system clock.
 */
`default_nettype none

module pors_clk_switch (
	input wire i_clk,
	input wire i_rst,
	input wire i_rc_tick,
	input wire i_main_tick,
	input wire i_want_main,
	output reg o_on_main,
	output wire o_chip_tick
);

	reg pending;

	// ----------------------------------------------------------------
	// swap only right after the old source, or the rc source when leaving main, ends a period
	// ----------------------------------------------------------------
	// the first tick of the new source is dropped in the swap cycle so
	// no shortened period can reach the core
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_on_main <= 1'b0;
			pending <= 1'b0;
		end else if (pending) begin
			o_on_main <= ~o_on_main;
			pending <= 1'b0;
		end else if (i_want_main != o_on_main) begin
			// a failed main oscillator may never tick again, so leaving
			// it must also accept an rc tick or the chip stalls
			if (o_on_main ? (i_main_tick | i_rc_tick) : i_rc_tick) begin
				pending <= 1'b1;
			end
		end
	end

	// old source is idle while the swap is pending
	assign o_chip_tick = pending ? 1'b0 :
		(o_on_main ? i_main_tick : i_rc_tick);

endmodule

`default_nettype wire

// *** rtl/pors_system_clock_output_pin_gen.v ***
/*
 * Machine-cycle state counter and the system clock output waveform.
 * Assumes one chip tick per oscillator period from the clock switch.
 */
`default_nettype none

`include "pors_defines.vh"

module pors_system_clock_output_pin_gen (
	input wire i_clk,
	input wire i_rst,
	input wire i_chip_tick,
	input wire i_slow_down,
	output reg [2:0] o_state,
	output reg o_system_clock_output_pin,
	output wire o_state_adv
);

	reg [4:0] prescale;
	reg [2:0] next_state;

	// ----------------------------------------------------------------
	// slow-down prescaler: states advance once per 32 chip ticks
	// ----------------------------------------------------------------
	assign o_state_adv = i_chip_tick &
		(~i_slow_down | (prescale == `PORS_SLOW_DIV));

	always @(posedge i_clk) begin
		if (i_rst) begin
			prescale <= 5'h00;
		end else if (i_chip_tick) begin
			prescale <= i_slow_down ? prescale + 5'd1 : 5'h00;
		end
	end

	// ----------------------------------------------------------------
	// six states per machine cycle
	// ----------------------------------------------------------------
	always @* begin
		next_state = (o_state == `PORS_LAST_STATE) ? 3'h0 :
			o_state + 3'd1;
	end

	// output is a flop so the pin never glitches between states
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_state <= 3'h0;
			o_system_clock_output_pin <= 1'b0;
		end else if (o_state_adv) begin
			o_state <= next_state;
			o_system_clock_output_pin <= (next_state == `PORS_THIRD_STATE);
		end
	end

endmodule

`default_nettype wire

// *** rtl/pors_top.v ***
/*
 * Power-on reset sequencer with oscillator watchdog, chip clock selection,
 * power-down exit and the gated system clock output, behind AXI4-Lite.
 * Assumes RC and main oscillator activity arrive as one-cycle tick
 * enables synchronous to I_SYS_CLK, and the reset pin is synchronous.
 */
// Local design decision: register access over AXI4-Lite.
`default_nettype none

`include "pors_defines.vh"

module pors_top (
	input wire I_SYS_CLK,
	input wire I_RST,
	input wire i_rc_tick,
	input wire i_main_tick,
	input wire i_ext_reset_n,
	input wire i_hardware_powerdown_input,
	input wire [31:0] i_awaddr,
	input wire i_awvalid,
	output wire o_awready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	input wire i_wvalid,
	output wire o_wready,
	output reg [1:0] o_bresp,
	output reg o_bvalid,
	input wire i_bready,
	input wire [31:0] i_araddr,
	input wire i_arvalid,
	output wire o_arready,
	output reg [31:0] o_rdata,
	output reg [1:0] o_rresp,
	output reg o_rvalid,
	input wire i_rready,
	output wire o_chip_tick,
	output wire o_core_reset,
	output wire o_powerdown,
	output wire [2:0] o_machine_state,
	output wire o_third_state,
	output wire o_port_one_bit_six_pin,
	output wire o_port_one_bit_six_pin_oe,
	output wire o_irq
);

	localparam ST_FAIL = 2'b00;
	localparam ST_SETTLE = 2'b01;
	localparam ST_RUN = 2'b10;

	reg [1:0] state;
	reg [9:0] settle_cnt;
	reg [4:0] win_rc;
	reg [4:0] win_main;
	reg osc_fail;
	reg osc_watchdog_status_flag;
	reg hw_pd;
	reg sw_pd;
	reg ext_rst_q;
	reg [7:0] conv_ctrl0;
	reg port_latch;
	reg slow_down;
	reg [`PORS_IRQ_W-1:0] irq_status;
	reg [`PORS_IRQ_W-1:0] irq_mask;
	reg [`PORS_IRQ_W-1:0] next_irq_status;
	reg [31:0] rd_word;
	reg rd_hit;

	wire ext_rst;
	wire wd_req;
	wire on_main;
	wire raw_tick;
	wire system_clock_output_pin;
	wire wr_go;
	wire rd_go;
	wire ev_fail;
	wire ev_release;
	wire ev_extrel;

	// register decode, used by both the write and the read path
	function is_mapped;
		input [7:0] a;
		begin
			if (a == `PORS_ADDR_CONV_CTRL0)
				is_mapped = 1'b1;
			else if (a == `PORS_ADDR_IRQ_STATUS)
				is_mapped = 1'b1;
			else if (a == `PORS_ADDR_IRQ_MASK)
				is_mapped = 1'b1;
			else if (a == `PORS_ADDR_SEQ_STATUS)
				is_mapped = 1'b1;
			else if (a == `PORS_ADDR_PORT_LATCH)
				is_mapped = 1'b1;
			else if (a == `PORS_ADDR_CONTROL)
				is_mapped = 1'b1;
			else
				is_mapped = 1'b0;
		end
	endfunction

	assign ext_rst = ~i_ext_reset_n;
	assign wd_req = (state != ST_RUN);

	// ----------------------------------------------------------------
	// oscillator failure detection
	// ----------------------------------------------------------------
	// judged over windows of RC ticks; one window of latency is the
	// price of not reacting to a single missing main tick
	always @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			win_rc <= 5'h00;
			win_main <= 5'h00;
			osc_fail <= 1'b1;
		end else begin
			if (i_rc_tick && win_rc == `PORS_DET_WINDOW - 5'd1) begin
				win_rc <= 5'h00;
				win_main <= 5'h00;
				osc_fail <= (win_main < `PORS_DET_WINDOW);
			end else begin
				if (i_rc_tick)
					win_rc <= win_rc + 5'd1;
				if (i_main_tick && win_main != `PORS_DET_WINDOW)
					win_main <= win_main + 5'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// watchdog sequencer
	// ----------------------------------------------------------------
	always @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			state <= ST_FAIL;
			settle_cnt <= 10'h000;
		end else begin
			case (state)
			ST_FAIL: begin
				settle_cnt <= 10'h000;
				if (!osc_fail)
					state <= ST_SETTLE;
			end
			ST_SETTLE: begin
				if (osc_fail) begin
					state <= ST_FAIL;
				end else if (i_rc_tick) begin
					if (settle_cnt == `PORS_SETTLE_RC_CYCLES - 10'd1)
						state <= ST_RUN;
					else
						settle_cnt <= settle_cnt + 10'd1;
				end
			end
			ST_RUN: begin
				if (osc_fail)
					state <= ST_FAIL;
			end
			default: state <= ST_FAIL;
			endcase
		end
	end

	pors_clk_switch u_switch (
		.i_clk(I_SYS_CLK),
		.i_rst(I_RST),
		.i_rc_tick(i_rc_tick),
		.i_main_tick(i_main_tick),
		.i_want_main(state == ST_RUN),
		.o_on_main(on_main),
		.o_chip_tick(raw_tick)
	);

	// ----------------------------------------------------------------
	// reset merge, power-down and watchdog flag
	// ----------------------------------------------------------------
	assign o_core_reset = wd_req | ext_rst;
	assign o_powerdown = hw_pd | sw_pd;
	// powered down parts of the core see no clock ticks
	assign o_chip_tick = raw_tick & ~o_powerdown;

	always @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			hw_pd <= 1'b0;
			sw_pd <= 1'b0;
			osc_watchdog_status_flag <= 1'b0;
			ext_rst_q <= 1'b0;
		end else begin
			ext_rst_q <= ext_rst;
			hw_pd <= i_hardware_powerdown_input & ~ext_rst;
			if (ext_rst)
				sw_pd <= 1'b0;
			else if (wr_go && i_wstrb[0] &&
				i_awaddr[7:0] == `PORS_ADDR_CONTROL && i_wdata[`PORS_CTRL_SWPD_BIT])
				sw_pd <= 1'b1;
			if (osc_fail)
				osc_watchdog_status_flag <= 1'b1;
			else if (ext_rst)
				osc_watchdog_status_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// port pin and system clock output
	// ----------------------------------------------------------------
	pors_system_clock_output_pin_gen u_system_clock_output_pin (
		.i_clk(I_SYS_CLK),
		.i_rst(I_RST | o_core_reset),
		.i_chip_tick(o_chip_tick),
		.i_slow_down(slow_down),
		.o_state(o_machine_state),
		.o_system_clock_output_pin(system_clock_output_pin),
		.o_state_adv()
	);

	// the core times its data move strobes to end in this state
	assign o_third_state = (o_machine_state == `PORS_THIRD_STATE);

	assign o_port_one_bit_six_pin = port_latch &
		(conv_ctrl0[`PORS_SYSTEM_CLOCK_OUTPUT_PIN_EN_BIT] ? system_clock_output_pin : 1'b1);
	assign o_port_one_bit_six_pin_oe = 1'b1;

	// ----------------------------------------------------------------
	// AXI4-Lite slave: address and data taken together
	// ----------------------------------------------------------------
	assign wr_go = i_awvalid & i_wvalid & ~o_bvalid;
	assign o_awready = wr_go;
	assign o_wready = wr_go;
	assign rd_go = i_arvalid & ~o_rvalid;
	assign o_arready = rd_go;

	always @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			o_bvalid <= 1'b0;
			o_bresp <= `PORS_RESP_OKAY;
		end else if (wr_go) begin
			o_bvalid <= 1'b1;
			o_bresp <= is_mapped(i_awaddr[7:0]) && i_awaddr[31:8] == 24'h000000 ?
				`PORS_RESP_OKAY : `PORS_RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// writable registers; reset state of the core also resets them
	always @(posedge I_SYS_CLK) begin
		if (I_RST || o_core_reset) begin
			conv_ctrl0 <= `PORS_CONV_CTRL0_RST;
			port_latch <= `PORS_PORT_LATCH_RST;
			slow_down <= 1'b0;
		end else if (wr_go && i_wstrb[0] && i_awaddr[31:8] == 24'h000000) begin
			if (i_awaddr[7:0] == `PORS_ADDR_CONV_CTRL0)
				conv_ctrl0 <= i_wdata[7:0];
			else if (i_awaddr[7:0] == `PORS_ADDR_PORT_LATCH)
				port_latch <= i_wdata[0];
			else if (i_awaddr[7:0] == `PORS_ADDR_CONTROL)
				slow_down <= i_wdata[`PORS_CTRL_SLOW_BIT];
		end
	end

	// mask survives core reset so software can see power-up events
	always @(posedge I_SYS_CLK) begin
		if (I_RST)
			irq_mask <= {`PORS_IRQ_W{1'b0}};
		else if (wr_go && i_wstrb[0] && i_awaddr[31:8] == 24'h000000 &&
			i_awaddr[7:0] == `PORS_ADDR_IRQ_MASK)
			irq_mask <= i_wdata[`PORS_IRQ_W-1:0];
	end

	// ----------------------------------------------------------------
	// sticky events, cleared by reading; a new event wins
	// ----------------------------------------------------------------
	assign ev_fail = osc_fail & ~osc_watchdog_status_flag;
	assign ev_release = (state == ST_SETTLE) & (settle_cnt ==
		`PORS_SETTLE_RC_CYCLES - 10'd1) & i_rc_tick & ~osc_fail;
	assign ev_extrel = ext_rst_q & ~ext_rst;

	always @* begin
		next_irq_status = irq_status;
		if (rd_go && i_araddr[31:0] == {24'h000000, `PORS_ADDR_IRQ_STATUS})
			next_irq_status = {`PORS_IRQ_W{1'b0}};
		next_irq_status = next_irq_status |
			{ev_extrel, ev_release, ev_fail};
	end

	always @(posedge I_SYS_CLK) begin
		if (I_RST)
			irq_status <= {`PORS_IRQ_W{1'b0}};
		else
			irq_status <= next_irq_status;
	end

	assign o_irq = |(irq_status & irq_mask);

	// read mux
	always @* begin
		rd_word = 32'h00000000;
		rd_hit = is_mapped(i_araddr[7:0]) && i_araddr[31:8] == 24'h000000;
		if (i_araddr[7:0] == `PORS_ADDR_CONV_CTRL0)
			rd_word = {24'h000000, conv_ctrl0};
		else if (i_araddr[7:0] == `PORS_ADDR_IRQ_STATUS)
			rd_word = {29'h00000000, irq_status};
		else if (i_araddr[7:0] == `PORS_ADDR_IRQ_MASK)
			rd_word = {29'h00000000, irq_mask};
		else if (i_araddr[7:0] == `PORS_ADDR_SEQ_STATUS)
			rd_word = {24'h000000, ext_rst, o_powerdown, on_main, osc_fail,
				osc_watchdog_status_flag, wd_req, state};
		else if (i_araddr[7:0] == `PORS_ADDR_PORT_LATCH)
			rd_word = {31'h00000000, port_latch};
		else if (i_araddr[7:0] == `PORS_ADDR_CONTROL)
			rd_word = {30'h00000000, sw_pd, slow_down};
		if (!rd_hit)
			rd_word = 32'h00000000;
	end

	always @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= `PORS_RESP_OKAY;
		end else if (rd_go) begin
			o_rvalid <= 1'b1;
			o_rdata <= rd_word;
			o_rresp <= rd_hit ? `PORS_RESP_OKAY : `PORS_RESP_SLVERR;
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// *** tb/pors_checker.sv ***
/* port checker for pors_top
   assumes it is bound onto every pors_top instance */
`default_nettype none
module pors_checker (
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire logic i_rc_tick,
	input wire logic i_main_tick,
	input wire logic i_ext_reset_n,
	input wire logic i_rready,
	input wire logic o_rvalid,
	input wire logic o_chip_tick,
	input wire logic o_core_reset,
	input wire logic o_powerdown,
	input wire logic [2:0] o_machine_state,
	input wire logic o_third_state,
	input wire logic o_port_one_bit_six_pin,
	input wire logic o_irq
);
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RST);
	logic [3:0] age;
	// cycles since reset, saturating; too short for a first fail decision
	always @(posedge I_SYS_CLK) begin
		if (I_RST)
			age <= 4'h0;
		else if (age != 4'hF)
			age <= age + 4'h1;
	end
	property p_fail_src;
		age != 4'hF |-> o_chip_tick == i_rc_tick;
	endproperty
	a_fail_src: assert property (p_fail_src)
		else $error("chip tick not from rc oscillator");
	property p_tick_cause;
		o_chip_tick |-> i_rc_tick || i_main_tick;
	endproperty
	a_tick_cause: assert property (p_tick_cause)
		else $error("chip tick without an oscillator tick");
	property p_pin_rst;
		o_core_reset && $past(o_core_reset) |-> o_port_one_bit_six_pin;
	endproperty
	a_pin_rst: assert property (p_pin_rst)
		else $error("pin not high in reset");
	property p_third;
		o_third_state == (o_machine_state == 3'h2);
	endproperty
	a_third: assert property (p_third)
		else $error("third state flag wrong");
	property p_step;
		!o_core_reset && !$past(o_core_reset) && $changed(o_machine_state)
		|-> o_machine_state == ($past(o_machine_state) == 3'h5 ? 3'h0
		: $past(o_machine_state) + 3'h1);
	endproperty
	a_step: assert property (p_step)
		else $error("machine state stepped wrongly");
	property p_ext;
		!i_ext_reset_n [*3] |-> o_core_reset;
	endproperty
	a_ext: assert property (p_ext)
		else $error("core left reset under external reset");
	property p_pd;
		!i_ext_reset_n [*3] |-> !o_powerdown;
	endproperty
	a_pd: assert property (p_pd)
		else $error("power-down kept under external reset");
	property p_irq0;
		$past(I_RST) |-> !o_irq;
	endproperty
	a_irq0: assert property (p_irq0)
		else $error("interrupt high after reset");
	property p_rdone;
		o_rvalid && i_rready |=> !o_rvalid;
	endproperty
	a_rdone: assert property (p_rdone)
		else $error("read answer not withdrawn");
	c_run: cover property ($fell(o_core_reset));
	c_pin: cover property ($rose(o_port_one_bit_six_pin) && o_third_state);
	c_irq: cover property ($rose(o_irq));
	c_pd: cover property ($fell(o_powerdown));
endmodule
bind pors_top pors_checker u_pors_checker (.I_SYS_CLK, .I_RST, .i_rc_tick,
	.i_main_tick, .i_ext_reset_n, .i_rready, .o_rvalid, .o_chip_tick,
	.o_core_reset, .o_powerdown, .o_machine_state, .o_third_state,
	.o_port_one_bit_six_pin, .o_irq);
`default_nettype wire

// *** tb/pors_osc_model.sv ***
/* oscillators and external reset circuit beside the sequencer
   assumes one system clock; all outputs change after its rising edge */
`default_nettype none
module pors_osc_model (
	input wire logic i_clk,
	input wire logic i_main_on,
	input wire logic i_hold,
	output logic o_rc_tick = 1'b0,
	output logic o_main_tick = 1'b0,
	output logic o_ext_reset_n = 1'b0
);
	// ----------------
	// tick sources
	// ----------------
	logic ph = 1'b0;
	// rc runs from power-on at half rate; main, once up, runs faster
	always @(posedge i_clk) begin
		ph <= ~ph;
		o_rc_tick <= ph;
		o_main_tick <= i_main_on;
		o_ext_reset_n <= ~i_hold;
	end
endmodule
`default_nettype wire

// *** tb/pors_top_bench.sv ***
/* self-checking bench for pors_top
   assumes the bound checker and the oscillator model */
`default_nettype none
module pors_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// stimulus and wiring
	// ----------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic main_on = 1'b0;
	logic hold = 1'b1;
	logic pd_req = 1'b0;
	logic [31:0] awaddr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] araddr = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	wire rc, mt, ext_n, awr, wrdy, arr, bv, rv, pin, third, core, pd, irq;
	wire oe;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] st;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	int rcn = 0;
	pors_osc_model u_pors_osc_model (.i_clk(clk), .i_main_on(main_on),
		.i_hold(hold), .o_rc_tick(rc), .o_main_tick(mt),
		.o_ext_reset_n(ext_n));
	pors_top u_pors_top (.I_SYS_CLK(clk), .I_RST(rst), .i_rc_tick(rc),
		.i_main_tick(mt), .i_ext_reset_n(ext_n),
		.i_hardware_powerdown_input(pd_req), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awr), .i_wdata(wdata),
		.i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wrdy),
		.o_bresp(bresp), .o_bvalid(bv), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arr),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
		.i_rready(rready), .o_chip_tick(), .o_core_reset(core),
		.o_powerdown(pd), .o_machine_state(st), .o_third_state(third),
		.o_port_one_bit_six_pin(pin), .o_port_one_bit_six_pin_oe(oe),
		.o_irq(irq));
	// 125 MHz clock
	always #4 clk = ~clk;
	// rc tick count and hang guard; longest path is two settle phases
	always @(posedge clk) begin
		rcn <= rcn + int'(rc);
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			num_errors++;
			results();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awr) awvalid <= 1'b0;
			if (wrdy) wvalid <= 1'b0;
			if (bv) begin
				chk(bresp, 32'h0);
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arr) arvalid <= 1'b0;
			if (rv) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		bus_rd(a, d, r);
		chk(d & m, e);
	endtask
	task automatic run_wait(output int n);
		logic [31:0] d;
		logic [1:0] r;
		n = rcn;
		do
			bus_rd(8'h08, d, r);
		while (d[1:0] != 2'h2);
		n = rcn - n;
	endtask
	// external reset pulse; power-down must drop while it is held
	task automatic pulse;
		hold <= 1'b1;
		repeat (4) @(posedge clk);
		chk(pd, 1'b0);
		hold <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic scan(input int len, input int eh, input int eb);
		int hi;
		int bad;
		hi = 0;
		bad = 0;
		repeat (len) begin
			@(negedge clk);
			hi += pin;
			bad += (pin !== third);
		end
		chk(hi, eh);
		chk(bad, eb);
	endtask
	task automatic t_power;
		int n;
		repeat (40) @(posedge clk);
		rdm(8'h08, 32'h7F, 32'h1C);
		chk(pin, 1'b1);
		chk(oe, 1'b1);
		main_on <= 1'b1;
		run_wait(n);
		chk(n >= 768 && n <= 808, 1'b1);
		rdm(8'h08, 32'h34, 32'h20);
		chk(core, 1'b1);
		$display("power-up done");
	endtask
	task automatic t_pd;
		pd_req <= 1'b1;
		repeat (4) @(posedge clk);
		chk(pd, 1'b0);
		pd_req <= 1'b0;
		hold <= 1'b0;
		repeat (4) @(posedge clk);
		chk(core, 1'b0);
		bus_wr(8'h10, 32'h2);
		repeat (2) @(posedge clk);
		chk(pd, 1'b1);
		pulse();
		pd_req <= 1'b1;
		repeat (4) @(posedge clk);
		chk(pd, 1'b1);
		pulse();
		pd_req <= 1'b0;
		$display("power-down done");
	endtask
	task automatic t_flag;
		int n;
		main_on <= 1'b0;
		repeat (80) @(posedge clk);
		rdm(8'h08, 32'h38, 32'h18);
		main_on <= 1'b1;
		run_wait(n);
		rdm(8'h08, 32'h08, 32'h08);
		chk(core, 1'b0);
		pulse();
		rdm(8'h08, 32'h08, 32'h00);
		$display("watchdog flag done");
	endtask
	task automatic t_irq;
		logic [31:0] d;
		logic [1:0] r;
		chk(irq, 1'b0);
		bus_wr(8'h04, 32'h7);
		@(posedge clk);
		chk(irq, 1'b1);
		rdm(8'h00, 32'h7, 32'h7);
		@(posedge clk);
		chk(irq, 1'b0);
		bus_rd(8'h20, d, r);
		chk(r, 2'h2);
		chk(d, 32'h0);
		rdm(8'hD8, 32'hFF, 32'h0);
		rdm(8'h0C, 32'h1, 32'h1);
		$display("interrupt done");
	endtask
	task automatic t_clk;
		bus_wr(8'hD8, 32'h40);
		scan(60, 10, 0);
		bus_wr(8'h0C, 32'h0);
		scan(12, 0, 2);
		bus_wr(8'h0C, 32'h1);
		bus_wr(8'h10, 32'h1);
		repeat (200) @(posedge clk);
		scan(384, 64, 0);
		$display("clock output done");
	endtask
	task automatic results;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_power();
		t_pd();
		t_flag();
		t_irq();
		t_clk();
		results();
	end
endmodule
`default_nettype wire
